// ---- sac_pkg.sv ----
// Constants for the successive-approximation converter control block.
// Assumes a 16-bit register port with byte addresses as seen by the CPU.
package sac_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [31:0] CTRL_ADDR = 32'hfffff328;
	localparam logic [31:0] TIMING_ADDR = 32'hfffff32a;
	localparam logic [31:0] RESULT_BASE = 32'hfffff330;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] TIMING_RESET = 8'h00;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CE_BIT = 7;
	localparam int BUSY_BIT = 6;
	localparam int BUF_BIT = 5;
	localparam int SWEEP_BIT = 4;
	localparam int BANK_BIT = 3;
	localparam int TRIG_HI = 5;
	localparam int TRIG_LO = 4;
	localparam int STAB_BIT = 3;
	localparam int SPEED_HI = 2;

	// ****************************************
	// Trigger modes
	// ****************************************
	localparam logic [1:0] TRIG_SOFT = 2'h0;
	localparam logic [1:0] TRIG_TIMER = 2'h1;
	localparam logic [1:0] TRIG_EXT = 2'h2;

	// ****************************************
	// Conversion geometry and timing
	// ****************************************
	localparam int RES_BITS = 10;
	localparam int PAD_BITS = 6;
	localparam logic [9:0] MSB_MASK = 10'h200;
	localparam logic [2:0] LAST_BUF = 3'h3;
	// Units per phase; one conversion is twelve units
	localparam logic [7:0] SAMPLE_UNITS = 8'h02;
	localparam logic [7:0] STAB_UNITS = 8'h06;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_WAIT = 5'h02,
		ST_STAB = 5'h04,
		ST_SAMP = 5'h08,
		ST_CONV = 5'h10
	} sac_state_type;

	// System clocks per conversion unit for each speed code
	function automatic logic [7:0] unit_cycles(input logic [2:0] speed);
		unique case (speed)
			3'h0: unit_cycles = 8'h18;
			3'h1: unit_cycles = 8'h12;
			3'h2: unit_cycles = 8'h0e;
			3'h3: unit_cycles = 8'h0a;
			3'h4: unit_cycles = 8'h09;
			3'h5: unit_cycles = 8'h07;
			3'h6: unit_cycles = 8'h05;
			3'h7: unit_cycles = 8'h04;
		endcase
	endfunction
endpackage

// ---- sac_core.sv ----
// Control logic of a 10-bit successive-approximation converter, 16 inputs.
// Assumes a comparator, ladder and sample switch outside, one 50 MHz clock.
//
// Operation
// R1 - Approximation register decides one bit per step, MSB down to LSB.
// R2 - Ladder tap code comes from the current approximation value.
// R3 - At LSB decision the result goes to the converted channel's register.
// R4 - Result registers reload on each conversion end; no reset value.
// R5 - Low six bits of approximation and result words are zero.
// R6 - Inputs sampled one at a time, held through their conversion.
// R7 - Input selection, sample timing and triggering follow both mode registers.
// R8 - Control register is read and written as byte or single bits.
// R9 - Control register write during conversion restarts it from the start.
// R10 - Bit 6 is a read-only busy flag; writes to it are ignored.
// R11 - Bit 7 enables the converter.
// R12 - Bit 5 selects one-buffer or four-buffer select mode.
// R13 - Bit 4 selects scan mode or select mode.
// R14 - Bit 3 selects inputs 0-7 or 8-15.
// R15 - Bits 2:0 name one input, or the last input of a scan.
// R16 - Enable set in timer or external trigger mode waits for a trigger.
// R17 - Enable clears only by a software write of 0 or reset.
// R18 - Enable set in software trigger mode starts conversion.
// R19 - Switch from software to hardware trigger with enable set waits at once.
// R20 - Timing register holds speed and trigger mode, byte or bit access.
// R21 - Outside four-buffer mode input k of the bank goes to result k.
// R22 - Result registers are read as 16-bit words only.
// R23 - Scan converts inputs upward and repeats while enabled; in hardware trigger mode the code waits for a trigger after the last input.
// R24 - Four-buffer mode fills results 0 to 3 in turn.
`timescale 1ns/1ns
`default_nettype none
module sac_core
	import sac_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Register port
	input wire logic [31:0] addr,
	input wire logic [15:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [15:0] rd_data,
	// Trigger inputs
	input wire logic timer_trig,
	input wire logic ext_trig,
	// Analog front end
	output logic [3:0] analog_inputs,
	output logic sample_en,
	output logic [9:0] tap_code,
	input wire logic cmp_above,
	// Status
	output logic busy
);
	// ****************************************
	// State
	// ****************************************
	sac_state_type state_reg, state_next;
	logic [7:0] ctrl_reg, ctrl_next;
	logic [7:0] timing_reg, timing_next;
	logic [9:0] approximation_register, approx_next;
	logic [9:0] mask_reg, mask_next;
	logic [7:0] cnt_reg, cnt_next;
	logic [2:0] chan_reg, chan_next;
	logic [2:0] buf_reg, buf_next;
	logic [15:0] rd_data_next;
	logic [9:0] result_hold_n [8];
	logic res_we;
	logic [2:0] res_dest;
	logic [9:0] res_value;

	logic ctrl_wr, timing_wr;
	logic [7:0] unit, stab_len, samp_len;
	logic converter_on;
	logic buffer_depth_select, channel_sweep_choice, input_bank_choice;
	logic [2:0] channel_number_field;
	logic [1:0] trig_mode;
	logic trig_hit, seq_last;
	logic [3:0] inputs_next;
	logic [9:0] tap_next;

	assign ctrl_wr = wr_en && addr == CTRL_ADDR;
	assign timing_wr = wr_en && addr == TIMING_ADDR;
	assign converter_on = ctrl_reg[CE_BIT]; // [R11]
	assign buffer_depth_select = ctrl_reg[BUF_BIT]; // [R12]
	assign channel_sweep_choice = ctrl_reg[SWEEP_BIT]; // [R13]
	assign input_bank_choice = ctrl_reg[BANK_BIT]; // [R14]
	assign channel_number_field = ctrl_reg[2:0];
	assign trig_mode = timing_reg[TRIG_HI:TRIG_LO]; // [R20]
	assign unit = unit_cycles(timing_reg[SPEED_HI:0]); // [R7]
	assign stab_len = 8'(STAB_UNITS * unit - 8'h01);
	assign samp_len = 8'(SAMPLE_UNITS * unit - 8'h01);
	assign trig_hit = (trig_mode == TRIG_TIMER && timer_trig) ||
		(trig_mode == TRIG_EXT && ext_trig);

	// Scan ends at the named input; four-buffer at the fourth buffer
	always_comb begin
		if (!channel_sweep_choice)
			seq_last = chan_reg == channel_number_field; // [R23]
		else if (buffer_depth_select)
			seq_last = buf_reg == LAST_BUF; // [R24]
		else
			seq_last = 1'b1;
	end

	// ****************************************
	// Front-end drive
	// ****************************************
	// Registered from next values so the pins move only on clock edges
	always_comb begin
		if (ctrl_next[SWEEP_BIT])
			inputs_next = {ctrl_next[BANK_BIT], ctrl_next[2:0]}; // [R15]
		else
			inputs_next = {ctrl_next[BANK_BIT], chan_next}; // [R14] [R15]
		tap_next = approx_next | mask_next; // [R2]
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			analog_inputs <= 4'h0;
			tap_code <= 10'h000;
		end else begin
			analog_inputs <= inputs_next;
			tap_code <= tap_next;
		end
	end
	assign sample_en = state_reg == ST_SAMP; // [R6]
	assign busy = state_reg == ST_STAB || state_reg == ST_SAMP ||
		state_reg == ST_CONV;

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		state_next = state_reg;
		ctrl_next = ctrl_reg;
		timing_next = timing_reg;
		approx_next = approximation_register;
		mask_next = mask_reg;
		cnt_next = cnt_reg;
		chan_next = chan_reg;
		buf_next = buf_reg;
		res_we = 1'b0;
		res_dest = buf_reg;
		res_value = approximation_register;
		if (ctrl_wr) begin
			// Busy bit is not stored; any write with enable set restarts the sequence
			ctrl_next = {wr_data[CE_BIT], 1'b0, wr_data[5:0]}; // [R8] [R10]
			chan_next = 3'h0;
			buf_next = 3'h0;
			approx_next = 10'h000;
			mask_next = 10'h000;
			if (!wr_data[CE_BIT])
				state_next = ST_IDLE; // [R17]
			else if (trig_mode != TRIG_SOFT)
				state_next = ST_WAIT; // [R16]
			else if (timing_reg[STAB_BIT]) begin
				state_next = ST_STAB; // [R9] [R18]
				cnt_next = stab_len;
			end else begin
				state_next = ST_SAMP; // [R9] [R18]
				cnt_next = samp_len;
			end
		end else if (timing_wr) begin
			timing_next = wr_data[7:0]; // [R20]
			if (converter_on && trig_mode == TRIG_SOFT &&
				wr_data[TRIG_HI:TRIG_LO] != TRIG_SOFT) begin
				state_next = ST_WAIT; // [R19]
				mask_next = 10'h000;
			end else if (state_reg == ST_WAIT &&
				wr_data[TRIG_HI:TRIG_LO] == TRIG_SOFT) begin
				state_next = ST_SAMP;
				cnt_next = samp_len;
				chan_next = 3'h0;
				buf_next = 3'h0;
			end
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
				end
				ST_WAIT: begin
					if (trig_hit) begin
						chan_next = 3'h0;
						buf_next = 3'h0;
						state_next = timing_reg[STAB_BIT] ? ST_STAB : ST_SAMP;
						cnt_next = timing_reg[STAB_BIT] ? stab_len : samp_len;
					end
				end
				ST_STAB: begin
					if (cnt_reg == 8'h00) begin
						state_next = ST_SAMP;
						cnt_next = samp_len;
					end else
						cnt_next = cnt_reg - 8'h01;
				end
				ST_SAMP: begin
					if (cnt_reg == 8'h00) begin
						state_next = ST_CONV;
						approx_next = 10'h000;
						mask_next = MSB_MASK; // [R1]
						cnt_next = unit - 8'h01;
					end else
						cnt_next = cnt_reg - 8'h01;
				end
				ST_CONV: begin
					if (cnt_reg != 8'h00)
						cnt_next = cnt_reg - 8'h01;
					else begin
						if (cmp_above)
							approx_next = approximation_register | mask_reg; // [R1]
						mask_next = mask_reg >> 1; // [R1]
						cnt_next = unit - 8'h01;
						if (mask_reg[0]) begin
							res_we = 1'b1; // [R3] [R4]
							res_value = approx_next;
							if (channel_sweep_choice && buffer_depth_select)
								res_dest = buf_reg; // [R24]
							else if (channel_sweep_choice)
								res_dest = channel_number_field; // [R21]
							else
								res_dest = chan_reg; // [R21]
							if (seq_last) begin
								chan_next = 3'h0;
								buf_next = 3'h0;
							end else begin
								chan_next = chan_reg + 3'h1; // [R23]
								buf_next = buf_reg + 3'h1; // [R24]
							end
							if (seq_last && trig_mode != TRIG_SOFT)
								state_next = ST_WAIT;
							else begin
								state_next = timing_reg[STAB_BIT] ? ST_STAB : ST_SAMP;
								cnt_next = timing_reg[STAB_BIT] ? stab_len : samp_len;
							end
						end
					end
				end
				default: state_next = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_reg <= ST_IDLE;
			ctrl_reg <= CTRL_RESET;
			timing_reg <= TIMING_RESET;
			approximation_register <= 10'h000;
			mask_reg <= 10'h000;
			cnt_reg <= 8'h00;
			chan_reg <= 3'h0;
			buf_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			ctrl_reg <= ctrl_next;
			timing_reg <= timing_next;
			approximation_register <= approx_next;
			mask_reg <= mask_next;
			cnt_reg <= cnt_next;
			chan_reg <= chan_next;
			buf_reg <= buf_next;
		end
	end

	// ****************************************
	// Result registers, no reset
	// ****************************************
	for (genvar i = 0; i < 8; i++) begin : g_res
		always_ff @(posedge ref_clk) begin
			if (res_we && res_dest == 3'(i))
				result_hold_n[i] <= res_value; // [R3] [R4]
		end
	end

	// ****************************************
	// Read port
	// ****************************************
	always_comb begin
		rd_data_next = 16'h0000;
		if (rd_en) begin
			if (addr == CTRL_ADDR)
				rd_data_next = {8'h00, ctrl_reg[7], busy, ctrl_reg[5:0]}; // [R8] [R10]
			else if (addr == TIMING_ADDR)
				rd_data_next = {8'h00, timing_reg}; // [R20]
			else if (addr[31:4] == RESULT_BASE[31:4] && !addr[0])
				rd_data_next = {result_hold_n[addr[3:1]], 6'h00}; // [R5] [R22]
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst)
			rd_data <= 16'h0000;
		else
			rd_data <= rd_data_next;
	end

	// ****************************************
	// Checks
	// ****************************************
	a_busy_read_flag: assert property (@(posedge ref_clk) disable iff (srst) // [R10]
		rd_en && addr == CTRL_ADDR |=> rd_data[BUSY_BIT] == $past(busy))
		else $error("busy bit read does not match state");

	a_busy_write_ignored: assert property (@(posedge ref_clk) disable iff (srst) // [R10]
		ctrl_wr |=> ctrl_reg[BUSY_BIT] == 1'b0 && ctrl_reg[CE_BIT] == $past(wr_data[CE_BIT]))
		else $error("control write stored wrong bits");

	a_result_low_zero: assert property (@(posedge ref_clk) disable iff (srst) // [R5]
		rd_en && addr[31:4] == RESULT_BASE[31:4] && !addr[0] |=> rd_data[5:0] == 6'h00)
		else $error("result low bits not zero");

	a_msb_first: assert property (@(posedge ref_clk) disable iff (srst) // [R1]
		state_reg == ST_SAMP && state_next == ST_CONV |=> mask_reg == MSB_MASK &&
		approximation_register == 10'h000)
		else $error("approximation did not start at msb");

	a_result_load: assert property (@(posedge ref_clk) disable iff (srst) // [R3]
		res_we |=> result_hold_n[$past(res_dest)] == $past(res_value))
		else $error("result register not loaded at conversion end");

	a_arm_waits: assert property (@(posedge ref_clk) disable iff (srst) // [R16]
		ctrl_wr && wr_data[CE_BIT] && trig_mode != TRIG_SOFT |=> state_reg == ST_WAIT)
		else $error("enable in hardware trigger mode did not wait");

	a_soft_start: assert property (@(posedge ref_clk) disable iff (srst) // [R18]
		ctrl_wr && wr_data[CE_BIT] && trig_mode == TRIG_SOFT |=> busy ##1
		(busy || $past(ctrl_wr) || $past(timing_wr)))
		else $error("software enable did not start conversion");

	a_mode_switch: assert property (@(posedge ref_clk) disable iff (srst) // [R19]
		timing_wr && converter_on && trig_mode == TRIG_SOFT &&
		wr_data[TRIG_HI:TRIG_LO] != TRIG_SOFT |=> state_reg == ST_WAIT)
		else $error("trigger mode change did not enter wait");

	a_hold_stable: assert property (@(posedge ref_clk) disable iff (srst) // [R6]
		state_reg == ST_CONV && !ctrl_wr && !timing_wr && state_next == ST_CONV
		|=> !sample_en && $stable(analog_inputs))
		else $error("input changed during conversion");

	a_enable_clear: assert property (@(posedge ref_clk) disable iff (srst) // [R17]
		$fell(converter_on) |-> $past(ctrl_wr) || $past(srst))
		else $error("enable cleared without software write");

	a_disable_stops: assert property (@(posedge ref_clk) disable iff (srst) // [R11]
		ctrl_wr && !wr_data[CE_BIT] |=> state_reg == ST_IDLE && !busy)
		else $error("enable cleared but converter kept running");

	a_restart_first: assert property (@(posedge ref_clk) disable iff (srst) // [R9]
		ctrl_wr && wr_data[CE_BIT] && trig_mode == TRIG_SOFT |=> busy &&
		approximation_register == 10'h000 && mask_reg == 10'h000 && chan_reg == 3'h0)
		else $error("control write did not restart from the first step");

	a_select_input: assert property (@(posedge ref_clk) disable iff (srst) // [R15]
		channel_sweep_choice |->
		analog_inputs == {input_bank_choice, channel_number_field})
		else $error("select mode drives the wrong input");

	a_scan_range: assert property (@(posedge ref_clk) disable iff (srst) // [R14] [R23]
		!channel_sweep_choice |-> analog_inputs[3] == input_bank_choice &&
		analog_inputs[2:0] <= channel_number_field)
		else $error("scan input outside the named range");

	a_result_index: assert property (@(posedge ref_clk) disable iff (srst) // [R21]
		res_we && !(channel_sweep_choice && buffer_depth_select) |->
		res_dest == analog_inputs[2:0])
		else $error("result stored under the wrong input number");

	a_four_slots: assert property (@(posedge ref_clk) disable iff (srst) // [R24]
		res_we && channel_sweep_choice && buffer_depth_select |-> res_dest <= LAST_BUF)
		else $error("four-buffer result outside slots 0 to 3");

	a_wait_holds: assert property (@(posedge ref_clk) disable iff (srst) // [R16]
		state_reg == ST_WAIT && !trig_hit && !ctrl_wr && !timing_wr |=>
		state_reg == ST_WAIT)
		else $error("converter left trigger wait without a trigger");

	a_bit_shift: assert property (@(posedge ref_clk) disable iff (srst) // [R1]
		state_reg == ST_CONV && cnt_reg == 8'h00 && !ctrl_wr && !timing_wr |=>
		mask_reg == $past(mask_reg) >> 1)
		else $error("approximation did not step to the next lower bit");

	a_odd_result: assert property (@(posedge ref_clk) disable iff (srst) // [R22]
		rd_en && addr[31:4] == RESULT_BASE[31:4] && addr[0] |=> rd_data == 16'h0000)
		else $error("odd result address returned data");
endmodule
`default_nettype wire

// ---- sac_front_model.sv ----
// Behavioural analog front end: input levels, sample switch and comparator.
// Assumes one ten-bit level per input in tap-code units, set by the bench.
`timescale 1ns/1ns
`default_nettype none
module sac_front_model
	import sac_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Levels of the sixteen inputs
	input wire logic [159:0] levels,
	// Converter side
	input wire logic [3:0] analog_inputs,
	input wire logic sample_en,
	input wire logic [9:0] tap_code,
	output logic cmp_above
);
	// ****************************************
	// Hold and compare
	// ****************************************
	logic [9:0] held_reg;
	logic [9:0] held_next;

	always_comb begin
		held_next = held_reg;
		if (sample_en) begin
			held_next = levels[analog_inputs * 10 +: 10];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			held_reg <= 10'h000;
		end else begin
			held_reg <= held_next;
		end
	end

	assign cmp_above = (held_reg >= tap_code);
endmodule
`default_nettype wire

// ---- sar_adc_control_test.sv ----
// Self-checking bench for the converter control block.
// Assumes the behavioural front end and speed code 7, four clocks a unit.
`timescale 1ns/1ns
`default_nettype none
module sar_adc_control_test
	import sac_pkg::*;
;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic [31:0] addr = 32'h0;
	logic [15:0] wr_data = 16'h0;
	logic wr_en = 1'b0, rd_en = 1'b0, timer_trig = 1'b0, ext_trig = 1'b0;
	logic [15:0] rd_data;
	logic [3:0] analog_inputs;
	logic sample_en, cmp_above, busy;
	logic [9:0] tap_code;
	logic [159:0] levels = '0;
	int bad_count = 0;
	int checks = 0;

	always #10 ref_clk = ~ref_clk;

	sac_core dut (.ref_clk(ref_clk), .srst(srst), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .timer_trig(timer_trig),
		.ext_trig(ext_trig), .analog_inputs(analog_inputs), .sample_en(sample_en),
		.tap_code(tap_code), .cmp_above(cmp_above), .busy(busy));

	sac_front_model model (.ref_clk(ref_clk), .srst(srst), .levels(levels),
		.analog_inputs(analog_inputs), .sample_en(sample_en), .tap_code(tap_code),
		.cmp_above(cmp_above));

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [15:0] res(input int i);
		return {levels[i * 10 +: 10], 6'h00};
	endfunction

	// Clocks per conversion unit; one conversion takes twelve units
	function automatic int unit_len(input int speed);
		int t[8] = '{24, 18, 14, 10, 9, 7, 5, 4};
		return t[speed];
	endfunction

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wr_data <= {8'h00, d};
		wr_en <= 1'b1;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [31:0] a, input logic [15:0] exp, input string name);
		@(posedge ref_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1;
		chk(name, exp, rd_data);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic pulse(input bit tmr);
		@(posedge ref_clk);
		timer_trig <= tmr;
		ext_trig <= ~tmr;
		@(posedge ref_clk);
		timer_trig <= 1'b0;
		ext_trig <= 1'b0;
	endtask

	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		int b;
		int k;
		int s;
		int u;
		logic [3:0] ch;
		logic [15:0] e;
		void'($urandom(32'h425b3f30));
		for (int i = 0; i < 16; i++) begin
			levels[i * 10 +: 10] = 10'($urandom());
		end
		repeat (10) @(posedge ref_clk);
		srst <= 1'b0;
		rd(CTRL_ADDR, {8'h00, CTRL_RESET}, "ctrl reset");
		rd(TIMING_ADDR, {8'h00, TIMING_RESET}, "timing reset");
		wr(CTRL_ADDR, 8'h40);
		rd(CTRL_ADDR, 16'h0000, "busy bit write");
		wr(TIMING_ADDR, 8'h07);
		rd(TIMING_ADDR, 16'h0007, "timing");
		rd(32'hfffff32c, 16'h0000, "unmapped");
		// Select, one buffer; level moves after sampling
		b = $urandom_range(1, 0);
		k = $urandom_range(7, 0);
		ch = 4'(b * 8 + k);
		e = res(ch);
		wr(CTRL_ADDR, {4'h9, ch});
		#1;
		chk("sampling", 16'h1, {15'h0, sample_en});
		chk("input", {12'h0, ch}, {12'h0, analog_inputs});
		cyc(8);
		chk("first tap", {6'h0, MSB_MASK}, {6'h0, tap_code});
		chk("holding", 16'h0, {15'h0, sample_en});
		cyc(12);
		levels[ch * 10 +: 10] <= ~levels[ch * 10 +: 10];
		rd(CTRL_ADDR, {8'h00, 4'hd, ch}, "busy read");
		cyc(28);
		wr(CTRL_ADDR, 8'h00);
		rd(RESULT_BASE + 32'(2 * k), e, "select result");
		// Rewrite mid-conversion restarts sampling
		wr(CTRL_ADDR, {4'h9, ch});
		cyc(20);
		wr(CTRL_ADDR, {4'h9, ch});
		#1;
		chk("restart", 16'h1, {15'h0, sample_en});
		wr(CTRL_ADDR, 8'h00);
		cyc(2);
		chk("stopped", 16'h0, {15'h0, busy});
		// Scan from input 0 to k
		k = $urandom_range(7, 1);
		wr(CTRL_ADDR, {4'h8, b[0], k[2:0]});
		cyc((k + 1) * 48 + 2);
		wr(CTRL_ADDR, 8'h00);
		for (int i = 0; i <= k; i++) begin
			rd(RESULT_BASE + 32'(2 * i), res(b * 8 + i), "scan result");
		end
		// Select, four buffers
		k = $urandom_range(7, 4);
		wr(CTRL_ADDR, {4'hb, b[0], k[2:0]});
		cyc(4 * 48 + 2);
		wr(CTRL_ADDR, 8'h00);
		for (int i = 0; i < 4; i++) begin
			rd(RESULT_BASE + 32'(2 * i), res(b * 8 + k), "four buffer");
		end
		// Stabilize phase at a random speed, select input ch again
		s = $urandom_range(7, 0);
		u = unit_len(s);
		wr(TIMING_ADDR, {5'h01, s[2:0]});
		wr(CTRL_ADDR, {4'h9, ch});
		#1;
		chk("stab busy", 16'h1, {15'h0, busy});
		cyc(6 * u - 1);
		chk("stabilizing", 16'h0, {15'h0, sample_en});
		cyc(1);
		chk("stab sample", 16'h1, {15'h0, sample_en});
		cyc(12 * u);
		wr(CTRL_ADDR, 8'h00);
		rd(RESULT_BASE + 32'(2 * ch[2:0]), res(ch), "stab result");
		// Hardware triggers
		wr(TIMING_ADDR, 8'h17);
		wr(CTRL_ADDR, 8'h90);
		cyc(2);
		chk("armed idle", 16'h0, {15'h0, busy});
		pulse(1'b0);
		cyc(2);
		chk("wrong trigger", 16'h0, {15'h0, busy});
		pulse(1'b1);
		cyc(2);
		chk("timer start", 16'h1, {15'h0, busy});
		cyc(52);
		chk("back to wait", 16'h0, {15'h0, busy});
		rd(CTRL_ADDR, 16'h0090, "enable kept");
		wr(TIMING_ADDR, 8'h07);
		cyc(2);
		chk("soft start", 16'h1, {15'h0, busy});
		wr(TIMING_ADDR, 8'h27);
		cyc(2);
		chk("to wait", 16'h0, {15'h0, busy});
		pulse(1'b0);
		cyc(2);
		chk("ext start", 16'h1, {15'h0, busy});
		wr(CTRL_ADDR, 8'h00);
		cyc(2);
		chk("cleared", 16'h0, {15'h0, busy});
		rd(RESULT_BASE + 32'h1, 16'h0000, "odd address");
		print_verdict();
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		bad_count++;
		print_verdict();
	end
endmodule
`default_nettype wire
